/* core/nvm_rom_pkg.sv */
package nvm_rom_pkg;
  // Geometry of the user nonvolatile store
  localparam int NUM_BANKS = 8;
  localparam int BANK_BITS = 128;
  localparam int BYTE_W = 8;
  localparam int BYTES_PER_BANK = BANK_BITS / BYTE_W;
  localparam int BANK_ADDR_W = 3;
  localparam int BYTE_ADDR_W = 4;
  localparam int ADDR_W = BANK_ADDR_W + BYTE_ADDR_W;
  localparam int TOTAL_BYTES = NUM_BANKS * BYTES_PER_BANK;
  // Field positions inside the read address
  localparam int BANK_LSB = BYTE_ADDR_W;
  localparam int BANK_MSB = ADDR_W - 1;
  localparam int BYTE_LSB = 0;
  localparam int BYTE_MSB = BYTE_ADDR_W - 1;
  // Reset value of the read data output
  localparam logic [BYTE_W-1:0] DATA_RST = 8'h00;
  // Scan-side port states
  typedef enum logic [1:0]
  {
    SCAN_IDLE = 2'b00,
    SCAN_PROG = 2'b01
  } scan_state_e;
endpackage

/* core/nvm_rom_array.sv */
`timescale 1ns/10ps
// Storage array: written only from the scan port, read combinationally by index
module nvm_rom_array #(
  parameter int DEPTH = nvm_rom_pkg::TOTAL_BYTES,
  parameter int AW = nvm_rom_pkg::ADDR_W,
  parameter int DW = nvm_rom_pkg::BYTE_W
)
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_resetn,
  // Scan-side write
  input wire logic i_wr_en,
  input wire logic [AW-1:0] i_wr_addr,
  input wire logic [DW-1:0] i_wr_data,
  // Read index
  input wire logic [AW-1:0] i_rd_addr,
  output logic [DW-1:0] o_rd_data
);
  logic [DW-1:0] mem [DEPTH];

  // Contents survive reset, as a nonvolatile store would
  always_ff @(posedge i_mclk)
  begin
    if (i_wr_en)
    begin
      mem[i_wr_addr] <= i_wr_data;
    end
  end

  assign o_rd_data = mem[i_rd_addr];
endmodule

/* core/user_nvm_byte_read_port.sv */
`timescale 1ns/10ps
module user_nvm_byte_read_port
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_resetn,
  // User read port
  input wire logic i_rd_req,
  input wire logic [nvm_rom_pkg::ADDR_W-1:0] i_rd_addr,
  output logic [nvm_rom_pkg::BYTE_W-1:0] o_rd_data,
  output logic o_rd_valid,
  // Scan programming port
  input wire logic i_scan_prog_en,
  input wire logic i_scan_wr,
  input wire logic i_scan_rd,
  input wire logic [nvm_rom_pkg::ADDR_W-1:0] i_scan_addr,
  input wire logic [nvm_rom_pkg::BYTE_W-1:0] i_scan_wdata,
  output logic [nvm_rom_pkg::BYTE_W-1:0] o_scan_rdata,
  output logic o_scan_rvalid
);
  localparam int AW = nvm_rom_pkg::ADDR_W;
  localparam int DW = nvm_rom_pkg::BYTE_W;

  // Joins bank and byte fields into a flat array index
  function automatic logic [AW-1:0] flat_index(input logic [AW-1:0] addr);
    logic [nvm_rom_pkg::BANK_ADDR_W-1:0] bank;
    logic [nvm_rom_pkg::BYTE_ADDR_W-1:0] idx;
    bank = addr[nvm_rom_pkg::BANK_MSB:nvm_rom_pkg::BANK_LSB];
    idx = addr[nvm_rom_pkg::BYTE_MSB:nvm_rom_pkg::BYTE_LSB];
    flat_index = {bank, idx};
  endfunction

  nvm_rom_pkg::scan_state_e state_reg;
  logic [AW-1:0] arr_addr;
  logic [DW-1:0] arr_data;
  logic arr_wr;
  logic user_rd;
  logic scan_rd;

  // Scan port owns the array while programming; user reads are refused
  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state_reg <= nvm_rom_pkg::SCAN_IDLE;
    end
    else
    begin
      case (state_reg)
        nvm_rom_pkg::SCAN_IDLE: if (i_scan_prog_en) state_reg <= nvm_rom_pkg::SCAN_PROG;
        nvm_rom_pkg::SCAN_PROG: if (!i_scan_prog_en) state_reg <= nvm_rom_pkg::SCAN_IDLE;
        default: state_reg <= nvm_rom_pkg::SCAN_IDLE;
      endcase
    end
  end

  // Only the scan port can write; user side has no write input at all
  assign arr_wr = (state_reg == nvm_rom_pkg::SCAN_PROG) && i_scan_wr;
  assign scan_rd = (state_reg == nvm_rom_pkg::SCAN_PROG) && i_scan_rd && !i_scan_wr;
  assign user_rd = (state_reg == nvm_rom_pkg::SCAN_IDLE) && i_rd_req;
  assign arr_addr = (state_reg == nvm_rom_pkg::SCAN_PROG) ? flat_index(i_scan_addr) : flat_index(i_rd_addr);

  nvm_rom_array #(
    .DEPTH(nvm_rom_pkg::TOTAL_BYTES),
    .AW(AW),
    .DW(DW)
  ) u_array (
    .i_mclk(i_mclk),
    .i_resetn(i_resetn),
    .i_wr_en(arr_wr),
    .i_wr_addr(flat_index(i_scan_addr)),
    .i_wr_data(i_scan_wdata),
    .i_rd_addr(arr_addr),
    .o_rd_data(arr_data)
  );

  // User byte captured on the sampling edge and held until the next read
  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_rd_data <= nvm_rom_pkg::DATA_RST;
      o_rd_valid <= 1'b0;
    end
    else
    begin
      o_rd_valid <= user_rd;
      if (user_rd)
      begin
        o_rd_data <= arr_data;
      end
    end
  end

  // Scan readback path, same one-cycle timing
  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_scan_rdata <= nvm_rom_pkg::DATA_RST;
      o_scan_rvalid <= 1'b0;
    end
    else
    begin
      o_scan_rvalid <= scan_rd;
      if (scan_rd)
      begin
        o_scan_rdata <= arr_data;
      end
    end
  end

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_resetn);

  sequence s_user_read;
    user_rd;
  endsequence

  sequence s_byte_out(logic [DW-1:0] d);
    o_rd_valid && o_rd_data == d;
  endsequence

  property p_read_latency;
    logic [DW-1:0] d;
    (s_user_read, d = arr_data) |=> s_byte_out(d);
  endproperty
  a_read_latency: assert property (p_read_latency) else $error("read byte not shown one cycle later");

  property p_hold;
    !user_rd |=> $stable(o_rd_data);
  endproperty
  a_hold: assert property (p_hold) else $error("read data changed without a read");

  property p_valid_pulse;
    o_rd_valid |-> $past(user_rd);
  endproperty
  a_valid_pulse: assert property (p_valid_pulse) else $error("valid without a read");

  property p_no_user_write;
    arr_wr |-> $past(i_scan_prog_en) && i_scan_wr;
  endproperty
  a_no_user_write: assert property (p_no_user_write) else $error("array write outside scan");

  property p_bank_decode;
    user_rd |-> arr_addr[AW-1:nvm_rom_pkg::BANK_LSB] == i_rd_addr[nvm_rom_pkg::BANK_MSB:nvm_rom_pkg::BANK_LSB];
  endproperty
  a_bank_decode: assert property (p_bank_decode) else $error("bank decode wrong");

  property p_byte_decode;
    user_rd |-> arr_addr[nvm_rom_pkg::BYTE_MSB:0] == i_rd_addr[nvm_rom_pkg::BYTE_MSB:nvm_rom_pkg::BYTE_LSB];
  endproperty
  a_byte_decode: assert property (p_byte_decode) else $error("byte decode wrong");

  property p_scan_read;
    logic [DW-1:0] d;
    (scan_rd, d = arr_data) |=> o_scan_rvalid && o_scan_rdata == d;
  endproperty
  a_scan_read: assert property (p_scan_read) else $error("scan readback wrong");

  property p_full_depth;
    user_rd |-> int'(arr_addr) < nvm_rom_pkg::NUM_BANKS * nvm_rom_pkg::BYTES_PER_BANK;
  endproperty
  a_full_depth: assert property (p_full_depth) else $error("index beyond store");

  // Session arbitration: the state moves one edge after the enable changes
  sequence s_session_req;
    state_reg == nvm_rom_pkg::SCAN_IDLE && i_scan_prog_en;
  endsequence

  sequence s_session_drop;
    state_reg == nvm_rom_pkg::SCAN_PROG && !i_scan_prog_en;
  endsequence

  property p_session_enter;
    s_session_req |=> state_reg == nvm_rom_pkg::SCAN_PROG;
  endproperty
  a_session_enter: assert property (p_session_enter) else $error("session not entered");

  property p_session_leave;
    s_session_drop |=> state_reg == nvm_rom_pkg::SCAN_IDLE;
  endproperty
  a_session_leave: assert property (p_session_leave) else $error("session not left");

  // User reads are refused for the whole session, so no stale byte can slip out
  property p_refuse_in_session;
    state_reg == nvm_rom_pkg::SCAN_PROG |=> !o_rd_valid;
  endproperty
  a_refuse_in_session: assert property (p_refuse_in_session) else $error("user read taken in session");

  property p_valid_needs_req;
    o_rd_valid |-> $past(i_rd_req) && $past(state_reg) == nvm_rom_pkg::SCAN_IDLE;
  endproperty
  a_valid_needs_req: assert property (p_valid_needs_req) else $error("valid without an idle request");

  // Scan readback is held between reads, like the user byte
  property p_scan_hold;
    !scan_rd |=> $stable(o_scan_rdata);
  endproperty
  a_scan_hold: assert property (p_scan_hold) else $error("scan data changed without a read");

  property p_scan_valid_pulse;
    o_scan_rvalid |-> $past(scan_rd);
  endproperty
  a_scan_valid_pulse: assert property (p_scan_valid_pulse) else $error("scan valid without a read");

  // A write strobe beats a read strobe in the same cycle; no readback follows
  property p_write_wins;
    arr_wr |=> !o_scan_rvalid;
  endproperty
  a_write_wins: assert property (p_write_wins) else $error("readback after a write strobe");

  // The scan index follows the same bank and byte split as the user index
  property p_scan_decode;
    scan_rd |-> arr_addr == {i_scan_addr[nvm_rom_pkg::BANK_MSB:nvm_rom_pkg::BANK_LSB],
      i_scan_addr[nvm_rom_pkg::BYTE_MSB:nvm_rom_pkg::BYTE_LSB]};
  endproperty
  a_scan_decode: assert property (p_scan_decode) else $error("scan index wrong");
endmodule

/* sim/nvm_user_model.sv */
`timescale 1ns/10ps
// Fabric user logic issuing byte reads
module nvm_user_model
(
  // Clock and request from bench
  input wire logic i_mclk,
  input wire logic i_go,
  input wire logic [6:0] i_addr,
  // Read port drive
  output logic o_rd_req,
  output logic [6:0] o_rd_addr
);
  initial o_rd_req = 1'b0;
  initial o_rd_addr = 7'h00;
  // Launch off the sampling edge; idle address toggles so no stale value looks valid
  always @(negedge i_mclk)
  begin
    o_rd_req <= i_go;
    o_rd_addr <= i_go ? i_addr : ~o_rd_addr;
  end
endmodule

/* sim/tb.sv */
`timescale 1ns/10ps
`define CHK(n, e, s) begin comparisons++; if ((e) !== (s)) begin fail_count++; \
  $display("unexpected %s exp %h seen %h", n, e, s); end end
module tb;
  logic i_mclk = 0, i_resetn = 0, go = 0, i_scan_prog_en = 0, i_scan_wr = 0, i_scan_rd = 0, rd_req;
  logic [6:0] ga = 0, i_scan_addr = 0, rd_addr;
  logic [7:0] i_scan_wdata = 0, last = nvm_rom_pkg::DATA_RST, mem [128], uq [$], sq [$];
  logic [7:0] o_rd_data, o_scan_rdata, exp_s;
  logic o_rd_valid, o_scan_rvalid;
  logic [31:0] seed = 32'h0000_5D5E, r;
  int fail_count = 0, comparisons = 0, cyc = 0;
  always #25 i_mclk = ~i_mclk;
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  nvm_user_model i_usr (.i_mclk(i_mclk), .i_go(go), .i_addr(ga), .o_rd_req(rd_req), .o_rd_addr(rd_addr));
  user_nvm_byte_read_port i_dut (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_rd_req(rd_req), .i_rd_addr(rd_addr),
    .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid), .i_scan_prog_en(i_scan_prog_en), .i_scan_wr(i_scan_wr),
    .i_scan_rd(i_scan_rd), .i_scan_addr(i_scan_addr), .i_scan_wdata(i_scan_wdata),
    .o_scan_rdata(o_scan_rdata), .o_scan_rvalid(o_scan_rvalid));
  // Scan strobe for one cycle; a readback notes the byte it must return
  task scan(input logic w, input logic [6:0] a, input logic [7:0] d);
    @(negedge i_mclk);
    {i_scan_wr, i_scan_rd, i_scan_addr, i_scan_wdata} = {w, !w, a, d};
    if (w) mem[a] = d;
    else sq.push_back(mem[a]);
  endtask
  // User read set after the rising edge, so the model forwards it cleanly at the falling one
  task rd(input logic [6:0] a);
    @(posedge i_mclk);
    {go, ga} = {1'b1, a};
    uq.push_back(mem[a]);
  endtask
  task results();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Outputs sampled mid-cycle, where registered values have settled
  always @(negedge i_mclk)
  begin
    if (o_rd_valid === 1'b1)
    begin
      `CHK("rd_q", 1'b1, uq.size() > 0)
      if (uq.size() > 0) last = uq.pop_front();
      `CHK("rd_data", last, o_rd_data)
    end
    else `CHK("rd_hold", last, o_rd_data)
    if (o_scan_rvalid === 1'b1)
    begin
      `CHK("scan_q", 1'b1, sq.size() > 0)
      if (sq.size() > 0)
      begin
        exp_s = sq.pop_front();
        `CHK("scan_data", exp_s, o_scan_rdata)
      end
    end
  end
  // Hang guard
  always @(posedge i_mclk)
    if (++cyc == 2000)
    begin
      fail_count++;
      results();
    end
  initial
  begin
    repeat (16) @(negedge i_mclk);
    i_resetn = 1;
    i_scan_prog_en = 1;
    @(negedge i_mclk);
    for (int i = 0; i < 128; i++)
    begin
      r = xs();
      scan(1'b1, i[6:0], r[7:0]);
    end
    for (int i = 127; i >= 0; i--) scan(1'b0, i[6:0], 8'h00);
    // Both strobes at once: the write lands, no readback; a user read meanwhile is refused, nothing noted
    @(negedge i_mclk);
    {i_scan_wr, i_scan_rd, i_scan_wdata} = {1'b1, 1'b1, 8'h3C};
    mem[i_scan_addr] = 8'h3C;
    @(posedge i_mclk);
    go = 1;
    @(negedge i_mclk);
    {i_scan_wr, i_scan_rd} = 2'b00;
    @(posedge i_mclk);
    go = 0;
    repeat (3) @(negedge i_mclk);
    i_scan_prog_en = 0;
    $display("test scan session done");
    repeat (3) @(negedge i_mclk);
    // Write strobe outside a session must leave the store intact
    {i_scan_wr, i_scan_addr, i_scan_wdata} = {1'b1, 7'h00, ~mem[0]};
    @(negedge i_mclk);
    i_scan_wr = 0;
    for (int i = 0; i < 128; i++) rd(i[6:0]);
    for (int i = 0; i < 64; i++)
    begin
      r = xs();
      rd(r[6:0]);
    end
    @(posedge i_mclk);
    go = 0;
    repeat (4) @(negedge i_mclk);
    `CHK("drain", 0, uq.size() + sq.size())
    $display("test user reads done");
    results();
  end
endmodule
